// ===== hdl/mfid_decoder.sv
// module: multi-function digital input decoder with AHB-Lite register slave
// What this block does
// - seven function selectors, codes up to 9f; unused terminals take code f
// - reset codes: 40, 41, 24, 14, 3, 4, 6 on terminals one to seven
// - three-wire initialization makes terminals five to seven codes 0, 3, 4
// - code 40 forward run/stop, code 41 reverse run/stop, two-wire
// - code 42 run/stop, code 43 forward/reverse, second two-wire scheme
// - code 0 terminal is direction; terminal one runs, terminal two stops
// - three-wire start only after run closed more than 50 ms
// - three-wire stop at once when stop terminal opens even briefly
// - three-wire direction forward when open, reverse when closed
// - remote two-wire run present at power-up ignored with blinking lamp unless acceptance set
// - code 1 closed selects local panel sources, open selects remote
// - remote uses primary sources unless a code 2 terminal picks them
// - any code 1 terminal disables the panel local/remote toggle key
// - local/remote lamp lit whenever local mode is active
// - local/remote change during run only when run-time switching enabled
// - code 2 open picks primary sources, closed picks secondary sources
// - primary/secondary change during run only when run-time switching enabled
// - codes 3 to 5 form three-bit selector of eight preset speeds
// - code f triggers nothing but its level stays readable
//
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module mfid_decoder (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // input terminals, closed is high
  input wire logic [6:0] terminal_in,
  // operator panel
  input wire logic panel_run,
  input wire logic local_remote_toggle,
  // decoded outputs
  output mfid_pkg::mfid_cmd_s cmd,
  output logic toggle_key_disabled,
  output logic local_remote_lamp,
  output logic run_lamp
);

  // ==========================================
  // registers
  logic [6:0][7:0] sel_q;
  logic [31:0] cfg_q;
  logic [7:0][15:0] preset_q;
  logic [6:0] sync1_q, sync2_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic run3_q, rev3_q, local_q, sec_q, panel_local_q, run_q, lockout_q;
  logic [2:0] pwrup_q;
  logic [31:0] qual_cnt_q, blink_cnt_q;
  logic blink_q;

  function automatic logic [6:0] match(input logic [6:0][7:0] s, input logic [7:0] code);
    logic [6:0] m;
    m = '0;
    for (int i = 0; i < mfid_pkg::NUM_TERMS; i++) begin
      m[i] = (s[i] == code);
    end
    return m;
  endfunction : match

  // ==========================================
  // input synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= terminal_in;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================
  // ahb-lite slave: write data phase, zero wait
  logic addr_ok;
  assign addr_ok = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else if (hready) begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_q[0] <= mfid_pkg::T1_RESET;
      sel_q[1] <= mfid_pkg::T2_RESET;
      sel_q[2] <= mfid_pkg::T3_RESET;
      sel_q[3] <= mfid_pkg::T4_RESET;
      sel_q[4] <= mfid_pkg::T5_RESET;
      sel_q[5] <= mfid_pkg::T6_RESET;
      sel_q[6] <= mfid_pkg::T7_RESET;
      cfg_q <= mfid_pkg::CONFIG_RESET;
      preset_q <= '0;
    end else if (wr_pend_q) begin
      if (wr_addr_q == mfid_pkg::INIT_OFF && hwdata[0]) begin
        sel_q[0] <= mfid_pkg::T1_RESET;
        sel_q[1] <= mfid_pkg::T2_RESET;
        sel_q[2] <= mfid_pkg::T3_RESET;
        sel_q[3] <= mfid_pkg::T4_RESET;
        sel_q[4] <= hwdata[1] ? mfid_pkg::T5_RESET_3W : mfid_pkg::T5_RESET;
        sel_q[5] <= hwdata[1] ? mfid_pkg::T6_RESET_3W : mfid_pkg::T6_RESET;
        sel_q[6] <= hwdata[1] ? mfid_pkg::T7_RESET_3W : mfid_pkg::T7_RESET;
      end
      for (int i = 0; i < mfid_pkg::NUM_TERMS; i++) begin
        if (wr_addr_q == mfid_pkg::TERM_SEL_BASE + 8'(4 * i) && hwdata[7:0] <= mfid_pkg::CODE_MAX) begin
          sel_q[i] <= hwdata[7:0];
        end
      end
      if (wr_addr_q == mfid_pkg::CONFIG_OFF) begin
        cfg_q <= {13'h0000, hwdata[18:0]};
      end
      for (int j = 0; j < 8; j++) begin
        if (wr_addr_q == mfid_pkg::PRESET_BASE + 8'(4 * j)) begin
          preset_q[j] <= hwdata[15:0];
        end
      end
    end
  end

  // read data registered in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (addr_ok && !hwrite) begin
      hrdata <= '0;
      for (int i = 0; i < mfid_pkg::NUM_TERMS; i++) begin
        if (haddr[7:0] == mfid_pkg::TERM_SEL_BASE + 8'(4 * i)) begin
          hrdata <= {24'h000000, sel_q[i]};
        end
      end
      for (int j = 0; j < 8; j++) begin
        if (haddr[7:0] == mfid_pkg::PRESET_BASE + 8'(4 * j)) begin
          hrdata <= {16'h0000, preset_q[j]};
        end
      end
      if (haddr[7:0] == mfid_pkg::CONFIG_OFF) begin
        hrdata <= cfg_q;
      end
      if (haddr[7:0] == mfid_pkg::STATUS_OFF) begin
        // raw terminal levels, code f terminals included
        hrdata <= {20'h00000, local_q, sec_q, run_q, cmd.reverse, lockout_q, sync2_q};
      end
    end
  end

  // ==========================================
  // function decode
  logic [6:0] m3w, mlr, mext, mfwd, mrev, mrs2, mdir2, ms0, ms1, ms2;
  logic three_wire, lr_pin_used, want_local, want_sec, run_req, rev_req;
  assign m3w = match(sel_q, mfid_pkg::FN_THREE_WIRE);
  assign mlr = match(sel_q, mfid_pkg::FN_LOCAL_REMOTE);
  assign mext = match(sel_q, mfid_pkg::FN_EXT_REF_SEL);
  assign mfwd = match(sel_q, mfid_pkg::FN_FWD_RUN);
  assign mrev = match(sel_q, mfid_pkg::FN_REV_RUN);
  assign mrs2 = match(sel_q, mfid_pkg::FN_RUN_STOP2);
  assign mdir2 = match(sel_q, mfid_pkg::FN_FWD_REV2);
  assign ms0 = match(sel_q, mfid_pkg::FN_STEP_BIT0);
  assign ms1 = match(sel_q, mfid_pkg::FN_STEP_BIT1);
  assign ms2 = match(sel_q, mfid_pkg::FN_STEP_BIT2);
  assign three_wire = |m3w;
  assign lr_pin_used = |mlr;
  assign want_local = lr_pin_used ? |(mlr & sync2_q) : panel_local_q;
  assign want_sec = |(mext & sync2_q);
  logic [2:0] step_idx;
  assign step_idx = {|(ms2 & sync2_q), |(ms1 & sync2_q), |(ms0 & sync2_q)};

  // ==========================================
  // three-wire sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qual_cnt_q <= '0;
    end else if (!sync2_q[0]) begin
      qual_cnt_q <= '0;
    end else if (three_wire && qual_cnt_q <= mfid_pkg::RUN_QUAL_CYC) begin
      qual_cnt_q <= qual_cnt_q + 32'd1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run3_q <= 1'b0;
    end else if (!three_wire || !sync2_q[1]) begin
      run3_q <= 1'b0;
    end else if (qual_cnt_q > mfid_pkg::RUN_QUAL_CYC) begin
      run3_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rev3_q <= 1'b0;
    end else begin
      rev3_q <= |(m3w & sync2_q);
    end
  end

  // run source follows the held mode, not the raw terminal
  always_comb begin
    if (local_q) begin
      run_req = panel_run;
      rev_req = 1'b0;
    end else if (three_wire) begin
      run_req = run3_q;
      rev_req = rev3_q;
    end else if (|mrs2) begin
      run_req = |(mrs2 & sync2_q);
      rev_req = |(mdir2 & sync2_q);
    end else begin
      // both closed cancels
      run_req = (|(mfwd & sync2_q)) ^ (|(mrev & sync2_q));
      rev_req = |(mrev & sync2_q) && !(|(mfwd & sync2_q));
    end
  end

  // ==========================================
  // source selection and power-up lockout
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      panel_local_q <= 1'b0;
    end else if (local_remote_toggle && !lr_pin_used) begin
      panel_local_q <= !panel_local_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      local_q <= 1'b0;
      sec_q <= 1'b0;
    end else if (!run_q || cfg_q[mfid_pkg::CFG_RUNSW_BIT]) begin
      local_q <= want_local;
      sec_q <= want_sec;
    end
  end

  // window spans the synchroniser so a remote two-wire run held at power-up is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwrup_q <= '1;
    end else begin
      pwrup_q <= {1'b0, pwrup_q[2:1]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lockout_q <= 1'b0;
    end else if (pwrup_q[0] && run_req && !cfg_q[mfid_pkg::CFG_PWRUP_BIT]) begin
      lockout_q <= 1'b1;
    end else if (!run_req) begin
      lockout_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_req && !(lockout_q || (pwrup_q[0] && !cfg_q[mfid_pkg::CFG_PWRUP_BIT]));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end else if (blink_cnt_q >= mfid_pkg::BLINK_CYC - 1) begin
      blink_cnt_q <= '0;
      blink_q <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'd1;
    end
  end

  // ==========================================
  // outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd <= '0;
      run_lamp <= 1'b0;
      local_remote_lamp <= 1'b0;
      toggle_key_disabled <= 1'b0;
    end else begin
      cmd.run <= run_q;
      cmd.reverse <= rev_req;
      cmd.local_mode <= local_q;
      cmd.secondary <= sec_q;
      // remote sources follow the code 2 terminal only if one is assigned
      cmd.ref_source <= sec_q && |mext ? cfg_q[mfid_pkg::CFG_SEC_REF_LSB +: 4] :
                        cfg_q[mfid_pkg::CFG_PRI_REF_LSB +: 4];
      cmd.run_source <= sec_q && |mext ? cfg_q[mfid_pkg::CFG_SEC_RUN_LSB +: 4] :
                        cfg_q[mfid_pkg::CFG_PRI_RUN_LSB +: 4];
      cmd.step_sel <= step_idx;
      cmd.step_speed <= preset_q[step_idx];
      run_lamp <= lockout_q ? blink_q : run_q;
      local_remote_lamp <= local_q;
      toggle_key_disabled <= lr_pin_used;
    end
  end

  // ==========================================
  // assertions
  stop_clears_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
    three_wire && !sync2_q[1] |=> !run3_q) else $error("run held with stop open");
  run_needs_qual_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(run3_q) |-> $past(qual_cnt_q) > mfid_pkg::RUN_QUAL_CYC) else $error("run before 50 ms");
  lamp_follows_a: assert property (@(posedge hclk) disable iff (!hresetn)
    local_q |=> local_remote_lamp) else $error("local lamp off");
  key_disable_a: assert property (@(posedge hclk) disable iff (!hresetn)
    lr_pin_used |=> $stable(panel_local_q)) else $error("toggle key active");
  run_switch_a: assert property (@(posedge hclk) disable iff (!hresetn)
    run_q && !cfg_q[mfid_pkg::CFG_RUNSW_BIT] |=> $stable(local_q)) else $error("mode changed in run");
  ext_switch_a: assert property (@(posedge hclk) disable iff (!hresetn)
    run_q && !cfg_q[mfid_pkg::CFG_RUNSW_BIT] |=> $stable(sec_q)) else $error("source changed in run");
  code_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sel_q[0] <= mfid_pkg::CODE_MAX) else $error("selector out of range");
  lockout_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
    lockout_q |=> !run_q) else $error("run while locked out");
  dir_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    three_wire |=> rev3_q == |($past(m3w) & $past(sync2_q))) else $error("direction wrong");

  // ==========================================
  // assertions on decode, sources and registers
  sync_chain_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sync2_q == $past(sync1_q))
    else $error("synchroniser stage skipped");
  two_wire_both_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !local_q && !three_wire && !(|mrs2) && |(mfwd & sync2_q) && |(mrev & sync2_q) |-> !run_req)
    else $error("run with both two-wire inputs closed");
  alt_scheme_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !local_q && !three_wire && |mrs2 |-> run_req == |(mrs2 & sync2_q) && rev_req == |(mdir2 & sync2_q))
    else $error("second two-wire scheme decoded wrong");
  three_wire_src_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !local_q && three_wire |-> run_req == run3_q)
    else $error("three-wire run not from sequencer");
  local_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
    local_q |-> run_req == panel_run && !rev_req)
    else $error("local run not from panel");
  remote_pri_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(sec_q && |mext) |=> cmd.ref_source == $past(cfg_q[mfid_pkg::CFG_PRI_REF_LSB +: 4]))
    else $error("primary reference source wrong");
  remote_sec_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sec_q && |mext |=> cmd.run_source == $past(cfg_q[mfid_pkg::CFG_SEC_RUN_LSB +: 4]))
    else $error("secondary run source wrong");
  step_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd.step_sel == $past(step_idx))
    else $error("step selector wrong");
  status_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && haddr[7:0] == mfid_pkg::STATUS_OFF |=> hrdata[6:0] == $past(sync2_q))
    else $error("status misses terminal levels");
  range_refuse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && wr_addr_q == mfid_pkg::TERM_SEL_BASE && hwdata[7:0] > mfid_pkg::CODE_MAX
    |=> $stable(sel_q[0]))
    else $error("out of range code accepted");
  init_three_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && wr_addr_q == mfid_pkg::INIT_OFF && hwdata[1:0] == 2'b11
    |=> sel_q[4] == mfid_pkg::T5_RESET_3W && sel_q[5] == mfid_pkg::T6_RESET_3W
    && sel_q[6] == mfid_pkg::T7_RESET_3W)
    else $error("three-wire defaults not loaded");
  lockout_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pwrup_q[0] && run_req && !cfg_q[mfid_pkg::CFG_PWRUP_BIT] |=> lockout_q)
    else $error("power-up run not locked out");
  key_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    lr_pin_used |=> toggle_key_disabled)
    else $error("toggle key not flagged disabled");

endmodule : mfid_decoder

`default_nettype wire

// ===== hdl/mfid_pkg.sv
// package: register map, reset values, function codes and timing for the input decoder
package mfid_pkg;

  // ==========================================
  // register map (byte offsets)
  localparam logic [7:0] TERM_SEL_BASE = 8'h00;
  localparam logic [7:0] CONFIG_OFF = 8'h1c;
  localparam logic [7:0] PRESET_BASE = 8'h20;
  localparam logic [7:0] STATUS_OFF = 8'h40;
  localparam logic [7:0] INIT_OFF = 8'h44;
  localparam int NUM_TERMS = 7;

  // ==========================================
  // reset values of the function selectors
  localparam logic [7:0] T1_RESET = 8'h40;
  localparam logic [7:0] T2_RESET = 8'h41;
  localparam logic [7:0] T3_RESET = 8'h24;
  localparam logic [7:0] T4_RESET = 8'h14;
  localparam logic [7:0] T5_RESET = 8'h03;
  localparam logic [7:0] T6_RESET = 8'h04;
  localparam logic [7:0] T7_RESET = 8'h06;
  localparam logic [7:0] T5_RESET_3W = 8'h00;
  localparam logic [7:0] T6_RESET_3W = 8'h03;
  localparam logic [7:0] T7_RESET_3W = 8'h04;
  localparam logic [7:0] CODE_MAX = 8'h9f;

  // ==========================================
  // function codes
  localparam logic [7:0] FN_THREE_WIRE = 8'h00;
  localparam logic [7:0] FN_LOCAL_REMOTE = 8'h01;
  localparam logic [7:0] FN_EXT_REF_SEL = 8'h02;
  localparam logic [7:0] FN_STEP_BIT0 = 8'h03;
  localparam logic [7:0] FN_STEP_BIT1 = 8'h04;
  localparam logic [7:0] FN_STEP_BIT2 = 8'h05;
  localparam logic [7:0] FN_THROUGH = 8'h0f;
  localparam logic [7:0] FN_FWD_RUN = 8'h40;
  localparam logic [7:0] FN_REV_RUN = 8'h41;
  localparam logic [7:0] FN_RUN_STOP2 = 8'h42;
  localparam logic [7:0] FN_FWD_REV2 = 8'h43;

  // ==========================================
  // config register fields
  localparam int CFG_PRI_REF_LSB = 0;
  localparam int CFG_PRI_RUN_LSB = 4;
  localparam int CFG_SEC_REF_LSB = 8;
  localparam int CFG_SEC_RUN_LSB = 12;
  localparam int CFG_PWRUP_BIT = 16;
  localparam int CFG_RUNSW_BIT = 17;
  localparam int CFG_PANEL_RUN_BIT = 18;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

  // ==========================================
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int RUN_QUAL_MS = 50;
  localparam int RUN_QUAL_CYC = RUN_QUAL_MS * (CLK_HZ / 1000);
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);

  // ==========================================
  // decoded command carrier
  typedef struct packed {
    logic run;
    logic reverse;
    logic local_mode;
    logic secondary;
    logic [3:0] ref_source;
    logic [3:0] run_source;
    logic [2:0] step_sel;
    logic [15:0] step_speed;
  } mfid_cmd_s;

endpackage : mfid_pkg

// ===== testbench/mfid_contacts.sv
// partner: switch contacts wired to the seven input terminals
`timescale 1ns/1ps
`default_nettype none

module mfid_contacts (
  // clock
  input wire logic hclk,
  // commanded contact states, closed is high
  input wire logic [6:0] closed,
  // terminal levels
  output var logic [6:0] terminal_in
);
  // ==========================================
  // contacts
  initial terminal_in = 7'h00;
  // each terminal follows its commanded contact one clock later, as the bench commands
  always @(posedge hclk) begin
    terminal_in <= closed;
  end
endmodule : mfid_contacts

`default_nettype wire

// ===== testbench/testbench.sv
// testbench: register and terminal scenarios for the input decoder
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ==========================================
  // signals
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [6:0] terminal_in;
  logic [6:0] closed = 7'h00;
  logic panel_run = 1'b0;
  logic toggle = 1'b0;
  mfid_pkg::mfid_cmd_s cmd;
  logic key_off;
  logic lamp_lr;
  logic lamp_run;
  logic [31:0] rd;
  logic [7:0] dflt [7] = '{8'h40, 8'h41, 8'h24, 8'h14, 8'h03, 8'h04, 8'h06};
  int bad_count = 0;
  int comparisons = 0;

  always #5 hclk = ~hclk;

  mfid_decoder u_mfid_decoder (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .terminal_in(terminal_in), .panel_run(panel_run), .local_remote_toggle(toggle),
    .cmd(cmd), .toggle_key_disabled(key_off), .local_remote_lamp(lamp_lr), .run_lamp(lamp_run));
  mfid_contacts u_mfid_contacts (.hclk(hclk), .closed(closed), .terminal_in(terminal_in));

  // ==========================================
  // tasks
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
  endtask : wait_ready

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk

  task automatic term(input logic [6:0] v);
    @(posedge hclk);
    closed <= v;
    repeat (6) @(posedge hclk);
    #1;
  endtask : term

  task automatic cmdchk(input logic r, input logic v);
    chk("run", {31'h0, r}, {31'h0, cmd.run});
    chk("reverse", {31'h0, v}, {31'h0, cmd.reverse});
  endtask : cmdchk

  task automatic do_reset();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
  endtask : do_reset

  // ==========================================
  // scenarios
  initial begin
    do_reset();
    for (int i = 0; i < 7; i++) begin
      rdchk("selector", 8'(4 * i), {24'h0, dflt[i]});
    end
    wr(8'h80, 32'h5a);
    rdchk("unmapped", 8'h80, 32'h0);
    $display("test reset values done");
    wr(8'h00, 32'ha0);
    rdchk("selector", 8'h00, 32'h40);
    wr(8'h00, 32'h9f);
    rdchk("selector", 8'h00, 32'h9f);
    wr(8'h00, 32'h0f);
    term(7'h01);
    cmdchk(1'b0, 1'b0);
    bus(mfid_pkg::STATUS_OFF, 1'b0, 32'h0);
    chk("status", 32'h01, rd & 32'h7f);
    term(7'h00);
    $display("test code range done");
    wr(mfid_pkg::INIT_OFF, 32'h3);
    for (int i = 4; i < 7; i++) begin
      rdchk("three wire", 8'(4 * i), 32'(i - 4 == 0 ? 8'h00 : dflt[i - 1]));
    end
    wr(mfid_pkg::INIT_OFF, 32'h1);
    for (int i = 0; i < 7; i++) begin
      rdchk("defaults", 8'(4 * i), {24'h0, dflt[i]});
    end
    $display("test init done");
    term(7'h01);
    cmdchk(1'b1, 1'b0);
    term(7'h02);
    cmdchk(1'b1, 1'b1);
    term(7'h03);
    cmdchk(1'b0, 1'b0);
    term(7'h00);
    wr(8'h00, 32'h42);
    wr(8'h04, 32'h43);
    term(7'h01);
    cmdchk(1'b1, 1'b0);
    term(7'h03);
    cmdchk(1'b1, 1'b1);
    term(7'h02);
    cmdchk(1'b0, 1'b1);
    term(7'h00);
    $display("test two wire done");
    wr(mfid_pkg::INIT_OFF, 32'h1);
    wr(8'h10, 32'h00);
    term(7'h03);
    repeat (2000) @(posedge hclk);
    #1;
    cmdchk(1'b0, 1'b0);
    term(7'h13);
    cmdchk(1'b0, 1'b1);
    term(7'h00);
    $display("test three wire done");
    wr(mfid_pkg::INIT_OFF, 32'h1);
    wr(8'h08, 32'h01);
    term(7'h00);
    chk("key off", 32'h1, {31'h0, key_off});
    @(posedge hclk);
    toggle <= 1'b1;
    @(posedge hclk);
    toggle <= 1'b0;
    term(7'h00);
    chk("local", 32'h0, {31'h0, cmd.local_mode});
    term(7'h04);
    chk("local", 32'h1, {31'h0, cmd.local_mode});
    chk("lamp", 32'h1, {31'h0, lamp_lr});
    panel_run <= 1'b1;
    term(7'h00);
    chk("panel run", 32'h1, {31'h0, cmd.run});
    chk("local", 32'h1, {31'h0, cmd.local_mode});
    panel_run <= 1'b0;
    term(7'h00);
    chk("lamp", 32'h0, {31'h0, lamp_lr});
    wr(mfid_pkg::CONFIG_OFF, 32'h0002_0000);
    term(7'h04);
    panel_run <= 1'b1;
    term(7'h00);
    chk("local", 32'h0, {31'h0, cmd.local_mode});
    panel_run <= 1'b0;
    $display("test local remote done");
    wr(mfid_pkg::INIT_OFF, 32'h1);
    wr(mfid_pkg::CONFIG_OFF, 32'h0000_4321);
    wr(8'h0c, 32'h0f);
    term(7'h08);
    chk("ref", 32'h1, {28'h0, cmd.ref_source});
    wr(8'h0c, 32'h02);
    term(7'h00);
    chk("ref", 32'h1, {28'h0, cmd.ref_source});
    chk("run src", 32'h2, {28'h0, cmd.run_source});
    term(7'h08);
    chk("ref", 32'h3, {28'h0, cmd.ref_source});
    chk("run src", 32'h4, {28'h0, cmd.run_source});
    term(7'h09);
    term(7'h01);
    chk("secondary", 32'h1, {31'h0, cmd.secondary});
    term(7'h00);
    $display("test source select done");
    wr(8'h18, 32'h05);
    for (int i = 0; i < 8; i++) begin
      wr(8'(mfid_pkg::PRESET_BASE + 4 * i), 32'h1000 + i);
    end
    for (int i = 0; i < 8; i++) begin
      term(7'(i << 4));
      chk("step", i, {29'h0, cmd.step_sel});
      chk("speed", 32'h1000 + i, {16'h0, cmd.step_speed});
    end
    term(7'h00);
    $display("test multi step done");
    @(posedge hclk);
    closed <= 7'h01;
    do_reset();
    term(7'h01);
    cmdchk(1'b0, 1'b0);
    bus(mfid_pkg::STATUS_OFF, 1'b0, 32'h0);
    chk("status", 32'h81, rd);
    chk("run lamp", 32'h0, {31'h0, lamp_run});
    term(7'h00);
    term(7'h01);
    cmdchk(1'b1, 1'b0);
    chk("run lamp", 32'h1, {31'h0, lamp_run});
    term(7'h00);
    $display("test power up done");
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
